// ===== pkg/pin_sync_if.sv
`timescale 1ns/10ps
interface pin_sync_if;
  logic [2:0] raw;
  logic [2:0] clean;
  modport sync_side (input raw, output clean);
  modport user_side (output raw, input clean);
endinterface

// ===== pkg/sideband_pkg.sv
package sideband_pkg;
  // clock and timing
  localparam int CLK_MHZ = 100;
  localparam int RESET_MIN_NS = 2000;
  localparam int INIT_NS = 20000;
  localparam logic [11:0] RESET_MIN_CYC = 12'((RESET_MIN_NS * CLK_MHZ + 999) / 1000);
  localparam logic [11:0] INIT_CYC = 12'((INIT_NS * CLK_MHZ + 999) / 1000);
  // pin synchroniser: select, reset, low power all rest at their pulled level
  localparam int PIN_SEL = 0;
  localparam int PIN_RST = 1;
  localparam int PIN_LP = 2;
  localparam logic [2:0] PIN_PULL = 3'h7;
  // management frame: header byte then data byte, msb first
  localparam logic [4:0] HDR_LAST = 5'h07;
  localparam logic [4:0] FRAME_LAST = 5'h0f;
  localparam int HDR_RW = 7;
  localparam int HDR_ADDR = 4;
  // management addresses
  localparam logic [2:0] ADDR_FLAGS = 3'h0;
  localparam logic [2:0] ADDR_MONSUM = 3'h1;
  localparam logic [2:0] ADDR_LPCTL = 3'h2;
  localparam logic [2:0] ADDR_TXEQ = 3'h3;
  localparam logic [2:0] ADDR_RXAMP = 3'h4;
  localparam logic [2:0] ADDR_RXPRE = 3'h5;
  localparam logic [2:0] ADDR_RECOV = 3'h6;
  // flag byte bit positions
  localparam int FL_TX_SIG = 0;
  localparam int FL_RX_SIG = 1;
  localparam int FL_TX_LOCK = 2;
  localparam int FL_RX_LOCK = 3;
  localparam int FL_TX_FAULT = 4;
  // low power control bits
  localparam int LP_CMD = 0;
  localparam int LP_OVR = 1;
  // reset values
  localparam logic [1:0] LP_RST = 2'h0;
  localparam logic [7:0] TXEQ_RST = 8'h00;
  localparam logic [7:0] RXAMP_RST = 8'h00;
  localparam logic [7:0] RXPRE_RST = 8'h00;
  localparam logic [1:0] RECOV_RST = 2'h3;
  // monitors: 4 lanes rx power, 4 tx power, 4 bias, supply, temperature
  localparam int N_MON = 14;
  localparam int MON_W = 8;
  localparam logic [N_MON*MON_W-1:0] WARN_LIMIT = {14{8'hc0}};
  localparam logic [N_MON*MON_W-1:0] ALARM_LIMIT = {14{8'he0}};
  typedef enum logic [1:0] {ST_RUN, ST_HOLD, ST_INIT} mod_state_e;
endpackage

// ===== rtl/module_sideband_control.sv
`timescale 1ns/10ps
module module_sideband_control (
  input wire logic REF_CLK,
  input wire logic RESET_N,
  input wire logic SCL,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE,
  input wire logic SELECT_N,
  input wire logic MODULE_RESET_N,
  input wire logic LOW_POWER_FORCE,
  output logic PRESENT_N,
  output logic ATTENTION_N_OUT,
  output logic ATTENTION_N_OE,
  input wire logic TX_SIGNAL_LOST_FLAG,
  input wire logic RX_SIGNAL_LOST_FLAG,
  input wire logic TX_LOCK_LOST_FLAG,
  input wire logic RX_LOCK_LOST_FLAG,
  input wire logic TX_FAULT,
  input wire logic [sideband_pkg::N_MON*sideband_pkg::MON_W-1:0] DIAGNOSTIC_MONITOR,
  output logic [sideband_pkg::N_MON-1:0] MON_WARN,
  output logic [sideband_pkg::N_MON-1:0] MON_ALARM,
  output logic LOW_POWER_STATE,
  output logic MODULE_READY,
  output logic [1:0] CLOCK_RECOVERY_CTRL,
  output logic [7:0] TX_EQ,
  output logic [7:0] RX_AMP,
  output logic [7:0] RX_PRE
);
  import sideband_pkg::*;

  // ---- link domain state (serial clock) ----
  typedef struct packed {
    logic [4:0] cnt;
    logic [15:0] sh;
    logic [7:0] tx;
    logic reading;
    logic sda_oe;
    logic [1:0] lp;
    logic [7:0] eq;
    logic [7:0] amp;
    logic [7:0] pre;
    logic [1:0] recov;
    logic wr_tgl;
    logic [15:0] stat_s1;
    logic [15:0] stat_s2;
  } link_s;

  // ---- reference domain state ----
  typedef struct packed {
    mod_state_e st;
    logic [11:0] cnt;
    logic wt_s1;
    logic wt_s2;
    logic wt_s3;
    logic [1:0] lp;
    logic [7:0] eq;
    logic [7:0] amp;
    logic [7:0] pre;
    logic [1:0] recov;
    logic [7:0] flags;
    logic [N_MON-1:0] warn;
    logic [N_MON-1:0] alarm;
    logic attn_oe;
    logic lp_state;
    logic ready;
    logic present_n;
  } ref_s;

  link_s lk_r;
  link_s lk_nxt;
  ref_s rf_r;
  ref_s rf_nxt;

  logic [15:0] sh_in;
  logic [7:0] rdata;
  logic [2:0] rd_addr;
  logic [2:0] wr_addr;
  logic [N_MON-1:0] warn_w;
  logic [N_MON-1:0] alarm_w;
  logic sel_clean;
  logic rst_low;
  logic lp_pin;

  pin_sync_if pins ();

  // pins settle through three stages before reference domain decisions use them; the link engine takes SELECT_N raw
  assign pins.raw[PIN_SEL] = SELECT_N;
  assign pins.raw[PIN_RST] = MODULE_RESET_N;
  assign pins.raw[PIN_LP] = LOW_POWER_FORCE;

  pin_sync i_pin_sync (
    .clk(REF_CLK),
    .rst_n(RESET_N),
    .sif(pins.sync_side)
  );

  assign sel_clean = pins.clean[PIN_SEL];
  assign rst_low = ~pins.clean[PIN_RST];
  assign lp_pin = pins.clean[PIN_LP];

  // fixed thresholds, held in constants so no write path can reach them
  genvar gi;
  generate
    for (gi = 0; gi < N_MON; gi++) begin : g_mon
      assign warn_w[gi] = DIAGNOSTIC_MONITOR[gi*MON_W +: MON_W] >= WARN_LIMIT[gi*MON_W +: MON_W];
      assign alarm_w[gi] = DIAGNOSTIC_MONITOR[gi*MON_W +: MON_W] >= ALARM_LIMIT[gi*MON_W +: MON_W];
    end
  endgenerate

  // read mux of the link side; flag bytes come through the status crossing
  assign sh_in = {lk_r.sh[14:0], SDA_IN};
  assign rd_addr = sh_in[HDR_ADDR +: 3];
  assign wr_addr = sh_in[8 + HDR_ADDR +: 3];

  always_comb begin
    unique case (rd_addr)
      ADDR_FLAGS: rdata = lk_r.stat_s2[7:0];
      ADDR_MONSUM: rdata = lk_r.stat_s2[15:8];
      ADDR_LPCTL: rdata = {6'h00, lk_r.lp};
      ADDR_TXEQ: rdata = lk_r.eq;
      ADDR_RXAMP: rdata = lk_r.amp;
      ADDR_RXPRE: rdata = lk_r.pre;
      ADDR_RECOV: rdata = {6'h00, lk_r.recov};
      default: rdata = 8'h00;
    endcase
  end

  // link frame engine: 8 header bits, then 8 data bits in or out
  always_comb begin
    lk_nxt = lk_r;
    lk_nxt.stat_s1 = {rf_r.warn[0], |rf_r.warn, 4'h0, |rf_r.warn, |rf_r.alarm, rf_r.flags};
    lk_nxt.stat_s2 = lk_r.stat_s1;
    if (SELECT_N) begin
      // deselected: frame position dropped, line released
      lk_nxt.cnt = 5'h00;
      lk_nxt.reading = 1'b0;
      lk_nxt.sda_oe = 1'b0;
    end else begin
      lk_nxt.sh = sh_in;
      lk_nxt.cnt = (lk_r.cnt == FRAME_LAST) ? 5'h00 : 5'(lk_r.cnt + 5'h01);
      if (lk_r.cnt == HDR_LAST) begin
        lk_nxt.reading = sh_in[HDR_RW];
        lk_nxt.tx = rdata;
      end else if (lk_r.cnt == FRAME_LAST) begin
        lk_nxt.reading = 1'b0;
        if (!sh_in[8 + HDR_RW]) begin
          unique case (wr_addr)
            ADDR_LPCTL: lk_nxt.lp = sh_in[1:0];
            ADDR_TXEQ: lk_nxt.eq = sh_in[7:0];
            ADDR_RXAMP: lk_nxt.amp = sh_in[7:0];
            ADDR_RXPRE: lk_nxt.pre = sh_in[7:0];
            ADDR_RECOV: lk_nxt.recov = sh_in[1:0];
            default: lk_nxt.lp = lk_r.lp; // status words are read only
          endcase
          lk_nxt.wr_tgl = ~lk_r.wr_tgl;
        end
      end else if (lk_r.reading) begin
        lk_nxt.tx = {lk_r.tx[6:0], 1'b0};
      end
      // open-drain data: drive only to send a zero
      lk_nxt.sda_oe = lk_nxt.reading & ~lk_nxt.tx[7];
    end
  end

  // the serial clock may stop between frames; nothing here waits on it
  always_ff @(posedge SCL or negedge RESET_N) begin
    if (!RESET_N) begin
      lk_r <= '{cnt: 5'h00, sh: 16'h0000, tx: 8'h00, reading: 1'b0, sda_oe: 1'b0,
                lp: LP_RST, eq: TXEQ_RST, amp: RXAMP_RST, pre: RXPRE_RST,
                recov: RECOV_RST, wr_tgl: 1'b0, stat_s1: 16'h0000, stat_s2: 16'h0000};
    end else begin
      lk_r <= lk_nxt;
    end
  end

  // reference domain: pulse qualify, init, shadow copy, attention
  always_comb begin
    rf_nxt = rf_r;
    rf_nxt.wt_s1 = lk_r.wr_tgl;
    rf_nxt.wt_s2 = rf_r.wt_s1;
    rf_nxt.wt_s3 = rf_r.wt_s2;
    rf_nxt.flags = {3'h0, TX_FAULT, RX_LOCK_LOST_FLAG, TX_LOCK_LOST_FLAG,
                    RX_SIGNAL_LOST_FLAG, TX_SIGNAL_LOST_FLAG};
    rf_nxt.warn = warn_w;
    rf_nxt.alarm = alarm_w;
    rf_nxt.present_n = 1'b0;
    unique case (rf_r.st)
      ST_RUN: begin
        if (!rst_low) begin
          rf_nxt.cnt = 12'h000; // short low pulses fall away here
        end else if (rf_r.cnt == RESET_MIN_CYC - 12'h001) begin
          rf_nxt.st = ST_HOLD;
          rf_nxt.cnt = 12'h000;
        end else begin
          rf_nxt.cnt = rf_r.cnt + 12'h001;
        end
      end
      ST_HOLD: begin
        if (!rst_low) begin
          rf_nxt.st = ST_INIT;
          rf_nxt.cnt = 12'h000;
        end
      end
      ST_INIT: begin
        if (rst_low) begin
          rf_nxt.st = ST_HOLD;
        end else if (rf_r.cnt == INIT_CYC - 12'h001) begin
          rf_nxt.st = ST_RUN;
          rf_nxt.cnt = 12'h000;
        end else begin
          rf_nxt.cnt = rf_r.cnt + 12'h001;
        end
      end
      // the spare state code falls back to a hold rather than running on
      default: rf_nxt.st = ST_HOLD;
    endcase
    // link words are stable before their toggle arrives, so one capture is safe
    if (rf_r.wt_s2 != rf_r.wt_s3) begin
      rf_nxt.lp = lk_r.lp;
      rf_nxt.eq = lk_r.eq;
      rf_nxt.amp = lk_r.amp;
      rf_nxt.pre = lk_r.pre;
      rf_nxt.recov = lk_r.recov;
    end
    // a module reset restores defaults until the next management write
    if (rf_nxt.st == ST_HOLD) begin
      rf_nxt.lp = LP_RST;
      rf_nxt.eq = TXEQ_RST;
      rf_nxt.amp = RXAMP_RST;
      rf_nxt.pre = RXPRE_RST;
      rf_nxt.recov = RECOV_RST;
    end
    rf_nxt.lp_state = (rf_r.st != ST_RUN) |
                      (rf_r.lp[LP_OVR] ? rf_r.lp[LP_CMD] : lp_pin);
    rf_nxt.attn_oe = (|rf_r.flags) | (|rf_r.alarm);
    rf_nxt.ready = (rf_nxt.st == ST_RUN);
  end

  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rf_r <= '{st: ST_RUN, cnt: 12'h000, wt_s1: 1'b0, wt_s2: 1'b0, wt_s3: 1'b0,
                lp: LP_RST, eq: TXEQ_RST, amp: RXAMP_RST, pre: RXPRE_RST,
                recov: RECOV_RST, flags: 8'h00, warn: '0, alarm: '0,
                attn_oe: 1'b0, lp_state: 1'b1, ready: 1'b1, present_n: 1'b0};
    end else begin
      rf_r <= rf_nxt;
    end
  end

  // every output straight from a flop
  assign SDA_OUT = 1'b0 & lk_r.sda_oe;
  assign SDA_OE = lk_r.sda_oe;
  assign PRESENT_N = rf_r.present_n;
  assign ATTENTION_N_OUT = 1'b0 & rf_r.attn_oe;
  assign ATTENTION_N_OE = rf_r.attn_oe;
  assign LOW_POWER_STATE = rf_r.lp_state;
  assign MODULE_READY = rf_r.ready;
  assign CLOCK_RECOVERY_CTRL = rf_r.recov;
  assign TX_EQ = rf_r.eq;
  assign RX_AMP = rf_r.amp;
  assign RX_PRE = rf_r.pre;
  assign MON_WARN = rf_r.warn;
  assign MON_ALARM = rf_r.alarm;

  // ---- checks ----
  property p_present;
    @(posedge REF_CLK) disable iff (!RESET_N)
      PRESENT_N == 1'b0;
  endproperty
  a_present: assert property (p_present) else $error("presence not low");

  property p_select;
    @(posedge SCL) disable iff (!RESET_N)
      SELECT_N |=> (lk_r.cnt == 5'h00) && !SDA_OE && !lk_r.reading;
  endproperty
  a_select: assert property (p_select) else $error("activity while deselected");

  property p_short;
    @(posedge REF_CLK) disable iff (!RESET_N)
      (rf_r.st == ST_RUN && rf_r.cnt < RESET_MIN_CYC - 12'h001) |=> rf_r.st == ST_RUN;
  endproperty
  a_short: assert property (p_short) else $error("reset taken before minimum width");

  property p_init;
    @(posedge REF_CLK) disable iff (!RESET_N)
      $rose(MODULE_READY) |-> $past(rf_r.st) == ST_INIT && $past(rf_r.cnt) == INIT_CYC - 12'h001;
  endproperty
  a_init: assert property (p_init) else $error("ready without full init");

  property p_lp_pin;
    @(posedge REF_CLK) disable iff (!RESET_N)
      (lp_pin && !rf_r.lp[LP_OVR]) |=> LOW_POWER_STATE;
  endproperty
  a_lp_pin: assert property (p_lp_pin) else $error("low power not held");

  property p_lp_ovr;
    @(posedge REF_CLK) disable iff (!RESET_N)
      (rf_r.st == ST_RUN && rf_r.lp[LP_OVR]) |=> LOW_POWER_STATE == $past(rf_r.lp[LP_CMD]);
  endproperty
  a_lp_ovr: assert property (p_lp_ovr) else $error("override not obeyed");

  property p_open_drain;
    @(posedge REF_CLK) disable iff (!RESET_N)
      ATTENTION_N_OUT == 1'b0 && SDA_OUT == 1'b0;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("line driven high");

  property p_attn;
    @(posedge REF_CLK) disable iff (!RESET_N)
      ##1 ATTENTION_N_OE == ($past(|rf_r.flags) || $past(|rf_r.alarm));
  endproperty
  a_attn: assert property (p_attn) else $error("attention does not follow flags");

  property p_limits;
    @(posedge REF_CLK) disable iff (!RESET_N)
      (MON_ALARM & ~MON_WARN) == '0;
  endproperty
  a_limits: assert property (p_limits) else $error("alarm without warning");

  property p_recov;
    @(posedge REF_CLK) disable iff (!RESET_N)
      (rf_r.st == ST_HOLD) |=> CLOCK_RECOVERY_CTRL == RECOV_RST;
  endproperty
  a_recov: assert property (p_recov) else $error("recovery not enabled by reset");
endmodule // module_sideband_control

// ===== rtl/pin_sync.sv
`timescale 1ns/10ps
module pin_sync (
  input wire logic clk,
  input wire logic rst_n,
  pin_sync_if.sync_side sif
);
  import sideband_pkg::*;

  typedef struct packed {
    logic [2:0] s1;
    logic [2:0] s2;
    logic [2:0] s3;
    logic [2:0] clean;
  } sync_s;

  sync_s st_r;
  sync_s st_nxt;

  // a bit moves only once stages two and three agree
  always_comb begin
    st_nxt = st_r;
    st_nxt.s1 = sif.raw;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    st_nxt.clean = ((st_r.s2 ~^ st_r.s3) & st_r.s3) | ((st_r.s2 ^ st_r.s3) & st_r.clean);
  end

  // reset to the pulled levels so an open select or reset pin reads inactive and an open low power pin forces low power
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= {4{PIN_PULL}};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign sif.clean = st_r.clean;

  property p_sync_agree;
    @(posedge clk) disable iff (!rst_n)
      (st_r.s2 != st_r.s3) |=> (st_r.clean == $past(st_r.clean));
  endproperty
  a_sync_agree: assert property (p_sync_agree) else $error("clean moved on disagreement");
endmodule // pin_sync

// ===== testbench/host_model.sv
`timescale 1ns/10ps
module host_model (
  output logic scl,
  output logic sda_line,
  output logic select_n,
  input wire logic sda_oe,
  input wire logic present_n,
  input wire logic attention_n_oe,
  output logic present_line,
  output logic attention_line
);
  logic host_pull;
  // open drain lines with host pull-ups, so a released line reads high
  assign sda_line = ~(host_pull | sda_oe);
  assign present_line = (present_n === 1'b0) ? 1'b0 : 1'b1;
  assign attention_line = (attention_n_oe === 1'b1) ? 1'b0 : 1'b1;
  // idle: clock parked low, module deselected
  initial begin
    scl = 1'b0;
    host_pull = 1'b0;
    select_n = 1'b1;
  end
  // one frame of header plus data; clock stands still outside frames
  task automatic frame(input logic [7:0] hdr, input logic [7:0] wdat, input logic sel,
                       output logic [7:0] rdat);
    logic [15:0] bits;
    bits = {hdr, wdat};
    rdat = 8'h00;
    select_n = ~sel;
    #30;
    for (int i = 15; i >= 0; i--) begin
      // on a read the host lets go of the data bits
      host_pull = (i < 8 && hdr[7]) ? 1'b0 : ~bits[i];
      #14;
      if (i < 8) begin
        rdat[i] = sda_line;
      end
      #1 scl = 1'b1;
      #15 scl = 1'b0;
    end
    host_pull = 1'b0;
    #30 select_n = 1'b1;
  endtask
endmodule // host_model

// ===== testbench/test_module_sideband_control.sv
`timescale 1ns/10ps
`define CHK(nm, exp, act) begin total_checks++; if ((act) !== (exp)) begin num_errors++; \
  $display("[ERR] %s expected %h seen %h", nm, exp, act); end end
module test_module_sideband_control;
  import sideband_pkg::*;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic mod_rst_n = 1'b1;
  logic lp_force = 1'b1;
  logic [4:0] flags = 5'h00;
  logic [N_MON*MON_W-1:0] mon = '0;
  logic scl, sda_line, select_n, sda_out, sda_oe, present_n, att_out, att_oe;
  logic present_line, attention_line, lp_state, ready;
  logic [N_MON-1:0] mon_warn, mon_alarm;
  logic [1:0] recov;
  logic [7:0] tx_eq, rx_amp, rx_pre;
  logic [7:0] set_v [3] = '{8'ha5, 8'h3c, 8'h81};
  logic [7:0] mon_v [3] = '{8'hbf, 8'hc0, 8'he0};
  logic [2:0] warn_e = 3'b110;
  logic [2:0] alarm_e = 3'b100;
  int num_errors = 0;
  int total_checks = 0;
  int cycles = 0;

  module_sideband_control i_module_sideband_control (
    .REF_CLK(ref_clk), .RESET_N(reset_n), .SCL(scl), .SDA_IN(sda_line),
    .SDA_OUT(sda_out), .SDA_OE(sda_oe), .SELECT_N(select_n),
    .MODULE_RESET_N(mod_rst_n), .LOW_POWER_FORCE(lp_force), .PRESENT_N(present_n),
    .ATTENTION_N_OUT(att_out), .ATTENTION_N_OE(att_oe),
    .TX_SIGNAL_LOST_FLAG(flags[FL_TX_SIG]), .RX_SIGNAL_LOST_FLAG(flags[FL_RX_SIG]),
    .TX_LOCK_LOST_FLAG(flags[FL_TX_LOCK]), .RX_LOCK_LOST_FLAG(flags[FL_RX_LOCK]),
    .TX_FAULT(flags[FL_TX_FAULT]), .DIAGNOSTIC_MONITOR(mon), .MON_WARN(mon_warn),
    .MON_ALARM(mon_alarm), .LOW_POWER_STATE(lp_state), .MODULE_READY(ready),
    .CLOCK_RECOVERY_CTRL(recov), .TX_EQ(tx_eq), .RX_AMP(rx_amp), .RX_PRE(rx_pre)
  );

  host_model i_host_model (
    .scl(scl), .sda_line(sda_line), .select_n(select_n), .sda_oe(sda_oe),
    .present_n(present_n), .attention_n_oe(att_oe), .present_line(present_line),
    .attention_line(attention_line)
  );

  // free running main clock
  initial begin
    forever #5 ref_clk = ~ref_clk;
  end

  // hang guard, well above the expected run of about 3600 cycles
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      close_out();
    end
  end

  task automatic close_out();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // inputs always change 1 ns after the edge
  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  // settle time covers the crossing back into the main clock domain
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    logic [7:0] unused;
    i_host_model.frame({1'b0, a, 4'h0}, v, 1'b1, unused);
    step(10);
  endtask

  task automatic rd(input logic [2:0] a, output logic [7:0] v);
    i_host_model.frame({1'b1, a, 4'h0}, 8'h00, 1'b1, v);
    step(2);
  endtask

  // main sequence
  initial begin
    logic [7:0] d;
    step(10);
    reset_n = 1'b1;
    step(6);
    `CHK("present", 1'b0, present_line)
    `CHK("recovery", 2'h3, recov)
    `CHK("ready", 1'b1, ready)
    `CHK("lp pulled", 1'b1, lp_state)
    lp_force = 1'b0;
    step(8);
    `CHK("lp released", 1'b0, lp_state)
    // settings written then read back
    for (int i = 0; i < 3; i++) wr(3'(ADDR_TXEQ + i), set_v[i]);
    `CHK("settings", {set_v[0], set_v[1], set_v[2]}, {tx_eq, rx_amp, rx_pre})
    for (int i = 0; i < 3; i++) begin
      rd(3'(ADDR_TXEQ + i), d);
      `CHK("readback", set_v[i], d)
    end
    // frames while deselected must leave no trace
    i_host_model.frame({1'b0, ADDR_RXAMP, 4'h0}, 8'h00, 1'b0, d);
    step(10);
    `CHK("deselected write", set_v[1], rx_amp)
    i_host_model.frame({1'b1, ADDR_TXEQ, 4'h0}, 8'h00, 1'b0, d);
    `CHK("deselected read", 8'hff, d)
    `CHK("sda drive", 1'b0, sda_out)
    // command override against the pin in both directions
    lp_force = 1'b1;
    wr(ADDR_LPCTL, 8'h02);
    `CHK("override off", 1'b0, lp_state)
    lp_force = 1'b0;
    wr(ADDR_LPCTL, 8'h03);
    `CHK("override on", 1'b1, lp_state)
    wr(ADDR_LPCTL, 8'h00);
    `CHK("pin again", 1'b0, lp_state)
    // each fault flag alone pulls attention and reads back
    for (int i = 0; i < 5; i++) begin
      flags = 5'h01 << i;
      step(4);
      `CHK("attention", 1'b0, attention_line)
      `CHK("att drive", 1'b0, att_out)
      rd(ADDR_FLAGS, d);
      `CHK("flags", {3'h0, flags}, d)
    end
    flags = 5'h00;
    step(4);
    `CHK("attention idle", 1'b1, attention_line)
    // threshold boundaries on the temperature monitor
    for (int i = 0; i < 3; i++) begin
      mon[13*MON_W +: MON_W] = mon_v[i];
      step(4);
      `CHK("warn", warn_e[i], mon_warn[13])
      `CHK("alarm", alarm_e[i], mon_alarm[13])
      `CHK("att alarm", ~alarm_e[i], attention_line)
    end
    mon = {N_MON{8'he0}};
    step(4);
    `CHK("all alarms", {N_MON{1'b1}}, mon_alarm)
    rd(ADDR_MONSUM, d);
    `CHK("summary alarm", 8'hc3, d)
    mon = '0;
    step(4);
    wr(ADDR_MONSUM, 8'hff);
    rd(ADDR_MONSUM, d);
    `CHK("summary fixed", 8'h00, d)
    // recovery switched off so the module reset has something to restore
    wr(ADDR_RECOV, 8'h00);
    `CHK("recovery off", 2'h0, recov)
    // a short low is ignored, a long one resets and reinitialises
    mod_rst_n = 1'b0;
    step(150);
    mod_rst_n = 1'b1;
    step(8);
    `CHK("short ready", 1'b1, ready)
    `CHK("short eq", set_v[0], tx_eq)
    mod_rst_n = 1'b0;
    step(210);
    `CHK("held ready", 1'b0, ready)
    `CHK("held eq", TXEQ_RST, tx_eq)
    `CHK("held recovery", RECOV_RST, recov)
    mod_rst_n = 1'b1;
    step(1990);
    `CHK("init ready", 1'b0, ready)
    step(20);
    `CHK("run ready", 1'b1, ready)
    close_out();
  end
endmodule // test_module_sideband_control
